// ### rtl/bfpgs_pkg.sv
package bfpgs_pkg;
   // ==================================================================
   // timing
   // ==================================================================
   localparam int unsigned CLK_FREQ_HZ     = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned PG_DELAY_US     = 3000;
   localparam int unsigned PG_PROP_US      = 1000;
   localparam int unsigned UV_QUAL_NS      = 8000;
   localparam int unsigned FCCM_HOLD_NS    = 64000;
   localparam int unsigned PG_DELAY_CYC    = PG_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned PG_PROP_CYC     = PG_PROP_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned UV_QUAL_CYC     = UV_QUAL_NS / CLK_PERIOD_NS;
   localparam int unsigned FCCM_HOLD_CYC   = FCCM_HOLD_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 16;
   localparam int unsigned SYNC_STAGES     = 3;
   // ==================================================================
   // target codes
   // ==================================================================
   localparam int unsigned CODE_W          = 3;
   localparam logic [2:0]  TGT_0P900       = 3'h0;
   localparam logic [2:0]  TGT_0P800       = 3'h1;
   localparam logic [2:0]  TGT_0P850       = 3'h2;
   localparam logic [2:0]  TGT_0P725       = 3'h3;
   localparam logic [2:0]  TGT_0P675       = 3'h4;
   // ==================================================================
   // sequencer states
   // ==================================================================
   typedef enum logic [2:0] {
      BFPGS_OFF,
      BFPGS_SOFTSTART,
      BFPGS_RUN,
      BFPGS_THERMAL,
      BFPGS_LATCHED
   } bfpgs_state_t;
endpackage : bfpgs_pkg

// ### rtl/bfpgs_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bfpgs_sync_if #(parameter int unsigned W = 10);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface : bfpgs_sync_if
`default_nettype wire

// ### rtl/bfpgs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bfpgs_sync
   import bfpgs_pkg::*;
#(
   parameter int unsigned W = 10
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // signals
   bfpgs_sync_if.sync s
);
   import bfpgs_pkg::*;
   // ==================================================================
   // three-stage sync, value changes when stages two and three agree
   // ==================================================================
   logic [W-1:0] st1_q, st2_q, st3_q, clean_q;
   wire  [W-1:0] agree = ~(st2_q ^ st3_q);
   assign s.clean = clean_q;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               st1_q[i]   <= 1'b0;
               st2_q[i]   <= 1'b0;
               st3_q[i]   <= 1'b0;
               clean_q[i] <= 1'b0;
            end else begin
               st1_q[i]   <= s.raw[i];
               st2_q[i]   <= st1_q[i];
               st3_q[i]   <= st2_q[i];
               clean_q[i] <= agree[i] ? st3_q[i] : clean_q[i];
            end
         end
      end
   endgenerate
endmodule : bfpgs_sync
`default_nettype wire

// ### rtl/bfpgs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module bfpgs_sequencer (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   // control pins
   input  wire logic                      enable,
   input  wire logic                      code_select_high,
   input  wire logic                      code_select_low,
   input  wire logic                      alt_option_strap,
   // comparator results
   input  wire logic                      bias_above_start,
   input  wire logic                      bias_above_hyst,
   input  wire logic                      bias_above_por,
   input  wire logic                      ramp_done,
   input  wire logic                      out_at_regulation,
   input  wire logic                      out_over_trip,
   input  wire logic                      out_under_trip,
   input  wire logic                      current_over_pos,
   input  wire logic                      current_over_neg,
   input  wire logic                      temp_over,
   input  wire logic                      temp_cooled,
   // loop request
   input  wire logic                      on_pulse_req,
   // outputs
   output var  logic                      high_side_on,
   output var  logic                      low_side_on,
   output var  logic                      forced_continuous,
   output var  logic                      ramp_start,
   output var  logic [bfpgs_pkg::CODE_W-1:0] target_code,
   output var  logic                      power_ok_flag_o,
   output var  logic                      power_ok_flag_oe,
   output var  logic                      bias_undervoltage_lockout,
   output var  logic                      output_overvoltage_trip,
   output var  logic                      output_undervoltage_trip,
   output var  logic                      switch_current_limit
);
   import bfpgs_pkg::*;

   // ==================================================================
   // input synchronisation
   // ==================================================================
   localparam int unsigned NIN = 15;
   bfpgs_sync_if #(.W(NIN)) sif ();
   assign sif.raw = {enable, code_select_high, code_select_low,
                     alt_option_strap, bias_above_start, bias_above_hyst,
                     bias_above_por, ramp_done, out_at_regulation,
                     out_over_trip, out_under_trip, current_over_pos,
                     current_over_neg, temp_over, temp_cooled};
   bfpgs_sync #(.W(NIN)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .s       (sif)
   );
   wire en_s      = sif.clean[14];
   wire vhi_s     = sif.clean[13];
   wire vlo_s     = sif.clean[12];
   wire strap_s   = sif.clean[11];
   wire bstart_s  = sif.clean[10];
   wire bhyst_s   = sif.clean[9];
   wire bpor_s    = sif.clean[8];
   wire rdone_s   = sif.clean[7];
   wire reg_s     = sif.clean[6];
   wire ovp_s     = sif.clean[5];
   wire uvp_s     = sif.clean[4];
   wire ocp_s     = sif.clean[3];
   wire ocn_s     = sif.clean[2];
   wire tover_s   = sif.clean[1];
   wire tcool_s   = sif.clean[0];

   // ==================================================================
   // target code decode
   // ==================================================================
   function automatic logic [CODE_W-1:0] code_decode(
      input logic hi, input logic lo, input logic strap);
      logic [CODE_W-1:0] c;
      c = TGT_0P900;
      case ({lo, hi})
         2'b00: c = TGT_0P900;
         2'b01: c = strap ? TGT_0P850 : TGT_0P800;
         2'b10: c = TGT_0P725;
         2'b11: c = TGT_0P675;
         default: c = TGT_0P900;
      endcase
      return c;
   endfunction
   wire [CODE_W-1:0] code_d = code_decode(vhi_s, vlo_s, strap_s);

   // ==================================================================
   // state and latches
   // ==================================================================
   bfpgs_state_t state_q, state_d;
   logic         bias_undervoltage_lockout_q, ovp_q, uvp_q, armed_q;
   logic         en_prev_q, vhi_prev_q, ramping_q, rdone_prev_q;
   logic [CNT_W-1:0] uvq_cnt_q, fccm_cnt_q, pg_cnt_q;
   logic         fccm_q, pg_oe_q, ramp_start_q, oc_q;
   logic [CODE_W-1:0] code_q;
   logic         hs_q, ls_q;

   wire en_fall    = en_prev_q & ~en_s;
   wire vhi_rise   = vhi_s & ~vhi_prev_q;
   wire code_chg   = (code_d != code_q);
   wire latched    = ovp_q | uvp_q;
   wire bias_undervoltage_lockout_now   = ~bhyst_s;
   wire uvp_qual   = uvp_s & ~ramping_q &
                     (uvq_cnt_q == CNT_W'(UV_QUAL_CYC - 1));
   wire ovp_now    = ovp_s & ~ramping_q & (state_q == BFPGS_RUN);
   wire running    = (state_q == BFPGS_SOFTSTART) |
                     (state_q == BFPGS_RUN);
   wire drop_pg    = ~en_s | bias_undervoltage_lockout_now | bias_undervoltage_lockout_q | latched | ovp_s |
                     (uvp_s & ~ramping_q) | ~running;
   // last count before power-ok release, qualification plus rise delay
   localparam int unsigned PG_TARGET = PG_DELAY_CYC + PG_PROP_CYC - 1;

   // ==================================================================
   // sequencer
   // ==================================================================
   always_comb begin
      state_d = state_q;
      case (state_q)
         BFPGS_OFF:
            if (en_s & armed_q & ~bias_undervoltage_lockout_q & ~latched & bstart_s)
               state_d = BFPGS_SOFTSTART;
         BFPGS_SOFTSTART:
            if (rdone_s)
               state_d = BFPGS_RUN;
         BFPGS_RUN:
            state_d = BFPGS_RUN;
         BFPGS_THERMAL:
            if (tcool_s & ~tover_s)
               state_d = BFPGS_OFF;
         BFPGS_LATCHED:
            state_d = BFPGS_LATCHED;
         default:
            state_d = BFPGS_OFF;
      endcase
      if (running & tover_s)
         state_d = BFPGS_THERMAL;
      if (ovp_now | uvp_qual | latched)
         state_d = BFPGS_LATCHED;
      if (~en_s | bias_undervoltage_lockout_now | bias_undervoltage_lockout_q)
         state_d = BFPGS_OFF;
      if (latched & ~ovp_q & en_fall)
         state_d = BFPGS_OFF;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q    <= BFPGS_OFF;
         en_prev_q  <= 1'b0;
         vhi_prev_q <= 1'b0;
         rdone_prev_q <= 1'b0;
         code_q     <= TGT_0P900;
      end else begin
         state_q    <= state_d;
         en_prev_q  <= en_s;
         vhi_prev_q <= vhi_s;
         rdone_prev_q <= rdone_s;
         code_q     <= code_d;
      end
   end

   // ==================================================================
   // fault latches
   // ==================================================================
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bias_undervoltage_lockout_q  <= 1'b0;
         ovp_q   <= 1'b0;
         uvp_q   <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (~bpor_s) begin
            bias_undervoltage_lockout_q  <= 1'b0;
            ovp_q   <= 1'b0;
            uvp_q   <= 1'b0;
            armed_q <= 1'b1;
         end else begin
            if (bias_undervoltage_lockout_now & armed_q)
               bias_undervoltage_lockout_q <= 1'b1;
            if (ovp_now)
               ovp_q <= 1'b1;
            if (uvp_qual)
               uvp_q <= 1'b1;
            else if (en_fall)
               uvp_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // ramp tracking and forced continuous hold
   // ==================================================================
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ramping_q    <= 1'b0;
         ramp_start_q <= 1'b0;
         fccm_q       <= 1'b0;
         fccm_cnt_q   <= '0;
      end else begin
         ramp_start_q <= (state_q == BFPGS_RUN) & code_chg;
         if ((state_q == BFPGS_RUN) & code_chg)
            ramping_q <= 1'b1;
         // end on a fresh ramp-done edge, not the stale level, or on leaving soft-start and run
         else if ((rdone_s & ~rdone_prev_q) | ~running)
            ramping_q <= 1'b0;
         if (~running) begin
            fccm_q     <= 1'b0;
            fccm_cnt_q <= '0;
         end else if ((state_q == BFPGS_RUN) & vhi_rise) begin
            fccm_q     <= 1'b1;
            fccm_cnt_q <= '0;
         end else if (fccm_q & ~ramping_q & rdone_s) begin
            if (fccm_cnt_q == CNT_W'(FCCM_HOLD_CYC - 1))
               fccm_q <= 1'b0;
            fccm_cnt_q <= fccm_cnt_q + 1'b1;
         end
      end
   end

   // ==================================================================
   // undervoltage qualification and power-ok timing
   // ==================================================================
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         uvq_cnt_q <= '0;
         pg_cnt_q  <= '0;
         pg_oe_q   <= 1'b1;
      end else begin
         if (uvp_s & ~ramping_q & running & ~uvp_qual)
            uvq_cnt_q <= uvq_cnt_q + 1'b1;
         else
            uvq_cnt_q <= '0;
         if (drop_pg | (~reg_s & ~ramping_q) |
             (state_q != BFPGS_RUN)) begin
            pg_cnt_q <= '0;
            pg_oe_q  <= 1'b1;
         end else if (ramping_q) begin
            pg_cnt_q <= pg_cnt_q;
         end else if (pg_cnt_q == CNT_W'(PG_TARGET)) begin
            pg_oe_q <= 1'b0;
         end else begin
            pg_cnt_q <= pg_cnt_q + 1'b1;
         end
      end
   end

   // ==================================================================
   // switch drive
   // ==================================================================
   wire allow_sw = running & ~latched & ~bias_undervoltage_lockout_q & ~bias_undervoltage_lockout_now;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hs_q <= 1'b0;
         ls_q <= 1'b0;
         oc_q <= 1'b0;
      end else begin
         oc_q <= ocp_s | ocn_s;
         hs_q <= allow_sw & on_pulse_req & ~ocp_s;
         ls_q <= allow_sw & ~(on_pulse_req & ~ocp_s) & ~ocn_s;
      end
   end

   assign high_side_on              = hs_q;
   assign low_side_on               = ls_q;
   assign forced_continuous         = fccm_q;
   assign ramp_start                = ramp_start_q;
   assign target_code               = code_q;
   assign power_ok_flag_o           = 1'b0;
   assign power_ok_flag_oe          = pg_oe_q;
   assign bias_undervoltage_lockout = bias_undervoltage_lockout_q;
   assign output_overvoltage_trip   = ovp_q;
   assign output_undervoltage_trip  = uvp_q;
   assign switch_current_limit      = oc_q;
endmodule : bfpgs_sequencer
`default_nettype wire

// ### test/bfpgs_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bfpgs_sequencer_chk
   import bfpgs_pkg::*;
(
   // clock, reset and inputs
   input wire logic clk, sys_rst, enable, bias_above_por,
   input wire logic ramp_done, out_at_regulation, out_under_trip,
   input wire logic current_over_pos, temp_over,
   // outputs
   input wire logic high_side_on, low_side_on, forced_continuous,
   input wire logic power_ok_flag_o, power_ok_flag_oe,
   input wire logic bias_undervoltage_lockout,
   input wire logic output_overvoltage_trip, output_undervoltage_trip
);
   // ==================================================================
   // run lengths of input levels
   // ==================================================================
   int unsigned reg_q, uv_q, rd_q, por_q;
   logic        fault;
   assign fault = bias_undervoltage_lockout | output_overvoltage_trip
                | output_undervoltage_trip;
   always_ff @(posedge clk) begin
      reg_q <= (sys_rst | ~(out_at_regulation & enable)) ? 0 : reg_q + 1;
      uv_q  <= (sys_rst | ~out_under_trip) ? 0 : uv_q + 1;
      rd_q  <= (sys_rst | ~ramp_done) ? 0 : rd_q + 1;
      por_q <= (sys_rst | ~bias_above_por) ? 0 : por_q + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_FLAG_DATA: assert property (power_ok_flag_o == 1'b0)
      else $error("power-ok data line not low");
   AST_FAULT_OFF: assert property (
      fault |=> !high_side_on && !low_side_on)
      else $error("switch on during latched fault");
   AST_FAULT_FLAG: assert property (fault |=> power_ok_flag_oe)
      else $error("power-ok released during fault");
   AST_EN_DROP: assert property (
      $fell(enable) |-> ##[1:6] power_ok_flag_oe)
      else $error("power-ok not pulled on enable fall");
   AST_PG_DELAY: assert property (
      $fell(power_ok_flag_oe) |-> reg_q >= PG_DELAY_CYC + PG_PROP_CYC)
      else $error("power-ok released early");
   AST_UV_QUAL: assert property (
      $rose(output_undervoltage_trip) |-> uv_q >= UV_QUAL_CYC)
      else $error("undervoltage latched early");
   AST_FCCM_HOLD: assert property (
      $fell(forced_continuous) && enable && bias_above_por && !fault
      && !temp_over && !out_under_trip |-> rd_q >= FCCM_HOLD_CYC)
      else $error("forced switching ended early");
   AST_OV_HOLD: assert property (
      output_overvoltage_trip && por_q > 8 |=> output_overvoltage_trip)
      else $error("overvoltage latch lost");
   AST_CUR_LIMIT: assert property (
      current_over_pos [*6] |-> !high_side_on)
      else $error("on-pulse during current limit");
   AST_THERMAL: assert property (
      temp_over [*7] |-> !high_side_on && !low_side_on)
      else $error("switching while over temperature");
endmodule // bfpgs_sequencer_chk
`default_nettype wire

// ### test/bfpgs_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// power stage: reference ramp and loop on-pulse requests
// ==================================================================
module bfpgs_stage_model #(
   parameter int unsigned RAMP = 50
) (
   input  wire logic clk,
   input  wire logic kick,
   input  wire logic ramp_start,
   output var  logic ramp_done,
   output var  logic out_at_regulation,
   output var  logic on_pulse_req
);
   int unsigned cnt_q = 0;
   int unsigned tick_q = 0;
   always_ff @(posedge clk) begin
      cnt_q  <= (kick | ramp_start) ? RAMP : (cnt_q != 0) ? cnt_q - 1 : 0;
      tick_q <= tick_q + 1;
   end
   assign ramp_done         = (cnt_q == 0);
   assign out_at_regulation = ramp_done;
   assign on_pulse_req      = tick_q[2];
endmodule // bfpgs_stage_model
`default_nettype wire

// ### test/bfpgs_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bfpgs_sequencer_bench;
   import bfpgs_pkg::*;
   localparam int unsigned RAMP = 50;
   logic clk = 1'b0, sys_rst = 1'b1, enable = 1'b0, kick = 1'b0;
   logic code_select_high = 1'b0, code_select_low = 1'b0;
   logic alt_option_strap = 1'b0, bias_above_start = 1'b0;
   logic bias_above_hyst = 1'b0, bias_above_por = 1'b0;
   logic out_over_trip = 1'b0, out_under_trip = 1'b0, temp_over = 1'b0;
   logic current_over_pos = 1'b0, current_over_neg = 1'b0;
   logic temp_cooled = 1'b0;
   wire logic ramp_done, out_at_regulation, on_pulse_req, ramp_start;
   wire logic high_side_on, low_side_on, forced_continuous;
   wire logic power_ok_flag_o, power_ok_flag_oe, switch_current_limit;
   wire logic bias_undervoltage_lockout, output_overvoltage_trip;
   wire logic output_undervoltage_trip;
   wire logic [CODE_W-1:0] target_code;
   int num_errors = 0;
   int n_tests = 0;
   bfpgs_sequencer u_dut (.*);
   bfpgs_stage_model #(.RAMP(RAMP)) u_stage (.clk(clk), .kick(kick),
      .ramp_start(ramp_start), .ramp_done(ramp_done),
      .out_at_regulation(out_at_regulation), .on_pulse_req(on_pulse_req));
   initial forever #50 clk = ~clk;
   // ==================================================================
   // shared tasks
   // ==================================================================
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string what, input logic [2:0] exp,
                      input logic [2:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic count_on(input int n, output int hits);
      hits = 0;
      repeat (n) begin
         cyc(1);
         if (high_side_on === 1'b1) hits++;
      end
   endtask
   task automatic power_on;
      enable = 1'b0;
      bias_above_por = 1'b0;
      cyc(8);
      bias_above_por = 1'b1;
      bias_above_hyst = 1'b1;
      bias_above_start = 1'b1;
      kick = 1'b1;
      cyc(1);
      kick = 1'b0;
      enable = 1'b1;
   endtask
   // ==================================================================
   // scenarios
   // ==================================================================
   task automatic t_power_good;
      int n;
      chk("reset_flag", 1, power_ok_flag_oe);
      chk("reset_code", TGT_0P900, target_code);
      power_on();
      n = 0;
      while (power_ok_flag_oe !== 1'b0 && n < 45000) begin
         cyc(1);
         n++;
      end
      chk("pg_not_early", 1, n >= PG_DELAY_CYC + PG_PROP_CYC);
      chk("pg_in_time", 1, n < PG_DELAY_CYC + PG_PROP_CYC + 200);
   endtask
   task automatic t_code_step;
      int n;
      code_select_high = 1'b1;
      cyc(8);
      chk("fccm_on", 1, forced_continuous);
      chk("target", TGT_0P800, target_code);
      chk("flag_blank", 0, power_ok_flag_oe);
      n = 8;
      while (forced_continuous === 1'b1 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk("fccm_hold", 1, n >= RAMP + FCCM_HOLD_CYC);
      chk("fccm_end", 1, n < RAMP + FCCM_HOLD_CYC + 40);
   endtask
   task automatic t_limits;
      int hits;
      current_over_pos = 1'b1;
      cyc(6);
      count_on(20, hits);
      chk("limit_flag", 1, switch_current_limit);
      chk("on_blocked", 0, hits != 0);
      current_over_pos = 1'b0;
      count_on(30, hits);
      chk("on_resumed", 1, hits != 0);
      out_under_trip = 1'b1;
      cyc(20);
      chk("uv_early", 0, output_undervoltage_trip);
      chk("uv_flag_first", 1, power_ok_flag_oe);
      cyc(80);
      chk("uv_latch", 1, output_undervoltage_trip);
      chk("uv_off", 0, {high_side_on, low_side_on});
      out_under_trip = 1'b0;
      cyc(20);
      chk("uv_held", 1, output_undervoltage_trip);
      enable = 1'b0;
      cyc(8);
      chk("uv_cleared", 0, output_undervoltage_trip);
   endtask
   task automatic t_thermal_over;
      int hits;
      power_on();
      cyc(100);
      temp_over = 1'b1;
      cyc(6);
      count_on(20, hits);
      chk("thermal_off", 0, hits != 0 || low_side_on);
      temp_over = 1'b0;
      temp_cooled = 1'b1;
      count_on(150, hits);
      chk("thermal_restart", 1, hits != 0);
      chk("no_latch", 0, {output_overvoltage_trip,
          output_undervoltage_trip, bias_undervoltage_lockout});
      temp_cooled = 1'b0;
      cyc(100);
      out_over_trip = 1'b1;
      cyc(8);
      chk("ov_latch", 1, output_overvoltage_trip);
      chk("ov_flag", 1, power_ok_flag_oe);
      out_over_trip = 1'b0;
      enable = 1'b0;
      cyc(8);
      enable = 1'b1;
      cyc(8);
      chk("ov_held", 1, output_overvoltage_trip);
   endtask
   task automatic t_lockout;
      int hits;
      power_on();
      cyc(100);
      chk("ov_por_clear", 0, output_overvoltage_trip);
      bias_above_hyst = 1'b0;
      cyc(8);
      chk("lockout", 1, bias_undervoltage_lockout);
      chk("lock_off", 0, {high_side_on, low_side_on});
      chk("lock_flag", 1, power_ok_flag_oe);
      bias_above_hyst = 1'b1;
      cyc(20);
      chk("lock_held", 1, bias_undervoltage_lockout);
      bias_above_por = 1'b0;
      bias_above_start = 1'b0;
      cyc(8);
      chk("lock_por_clear", 0, bias_undervoltage_lockout);
      bias_above_por = 1'b1;
      cyc(20);
      count_on(30, hits);
      chk("no_start", 0, hits != 0);
   endtask
   initial begin
      cyc(8);
      sys_rst = 1'b0;
      cyc(2);
      t_power_good();
      t_code_step();
      t_limits();
      t_thermal_over();
      t_lockout();
      give_verdict();
   end
   initial begin
      #(60000 * CLK_PERIOD_NS);
      num_errors++;
      give_verdict();
   end
endmodule // bfpgs_sequencer_bench
bind bfpgs_sequencer bfpgs_sequencer_chk u_chk (.*);
`default_nettype wire
